// file: src/srt_xfer.sv
// Status register transfer execute unit with an APB register port
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module srt_xfer
  import srt_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // General register write-back
  output logic             gpr_wr_en,
  output logic [3:0]       gpr_wr_idx,
  output logic [31:0]      gpr_wr_data,
  // Current status word for the core
  output logic [31:0]      cur_status
);

  // Rotate right by twice the rotate field
  function automatic logic [31:0] srt_rot_imm(input logic [3:0]  rot,
                                              input logic [7:0]  imm);
    logic [63:0] dbl;
    logic [4:0]  amt;
    dbl = {24'h00_0000, imm, 24'h00_0000, imm};
    amt = {rot, 1'b0};
    srt_rot_imm = 32'(dbl >> amt);
  endfunction

  // Bank index for a mode; usr and sys have no saved word
  function automatic logic [3:0] srt_bank(input logic [4:0] mode);
    if (mode == SRT_MODE_FIQ) begin
      srt_bank = {1'b1, SRT_BANK_FIQ};
    end else if (mode == SRT_MODE_IRQ) begin
      srt_bank = {1'b1, SRT_BANK_IRQ};
    end else if (mode == SRT_MODE_SVC) begin
      srt_bank = {1'b1, SRT_BANK_SVC};
    end else if (mode == SRT_MODE_ABT) begin
      srt_bank = {1'b1, SRT_BANK_ABT};
    end else if (mode == SRT_MODE_UND) begin
      srt_bank = {1'b1, SRT_BANK_UND};
    end else begin
      srt_bank = 4'h0;
    end
  endfunction

  srt_state_t  state_r;
  logic [31:0] instr_r;
  logic [31:0] operand_r;
  logic [31:0] cur_r;
  logic [31:0] cur_nxt;
  logic [31:0] saved_r [SRT_NBANK];
  logic [31:0] result_r;
  logic [3:0]  status_r;
  logic [3:0]  status_nxt;

  // Bus decode
  logic access, wr_acc, rd_acc;
  assign access = psel && penable;
  assign wr_acc = access && pwrite;
  assign rd_acc = access && !pwrite;

  logic [3:0] bank_sel;
  logic       bank_ok;
  assign bank_sel = srt_bank(cur_r[SRT_MODE_HI:0]);
  assign bank_ok  = bank_sel[3];

  logic        privileged;
  logic [31:0] saved_cur;
  assign privileged = (cur_r[SRT_MODE_HI:0] != SRT_MODE_USR);
  assign saved_cur  = bank_ok ? saved_r[bank_sel[2:0]] : SRT_ZERO_WORD;

  // Decode of the pending instruction
  logic is_read, is_wr_full, is_wr_flag, cond_pass, psel_bit;
  assign is_read =
    ((instr_r & SRT_RD_MASK) == SRT_RD_MATCH);
  assign is_wr_full =
    ((instr_r & SRT_WRF_MASK) == SRT_WRF_MATCH);
  assign is_wr_flag =
    ((instr_r & SRT_WRG_MASK) == SRT_WRG_MATCH) &&
    (instr_r[SRT_IMM_BIT] || ((instr_r & SRT_WRG_RMSK) == SRT_ZERO_WORD));
  assign psel_bit = instr_r[SRT_PSEL];

  // Word named by the select bit: the mode's saved bank or the current
  logic [31:0] psr_word;
  assign psr_word = psel_bit ? saved_cur : cur_r;

  srt_cond u_cond (
    .cond (instr_r[SRT_COND_HI:SRT_COND_LO]),
    .nzcv (cur_r[SRT_COND_HI:SRT_COND_LO]),
    .pass (cond_pass)
  );

  // Source value of the flag-only form: register or rotated immediate
  logic [31:0] flag_src;
  assign flag_src = instr_r[SRT_IMM_BIT] ?
    srt_rot_imm(instr_r[SRT_ROT_HI:SRT_ROT_LO],
                instr_r[SRT_IMM_HI:0]) :
    operand_r;

  // New value for the selected status word
  logic [31:0] wr_base, wr_val;
  always_comb begin
    wr_base = psr_word;
    if (is_wr_flag) begin
      wr_val = {flag_src[SRT_COND_HI:SRT_FLAG_LO],
                wr_base[SRT_CTRL_HI:0]};
    end else begin
      wr_val = operand_r;
    end
  end

  logic do_exec;
  assign do_exec = (state_r == SRT_EXEC) && cond_pass;

  // Sequencer: an instruction write arms one execute cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SRT_IDLE;
    end else begin
      case (state_r)
        SRT_IDLE: begin
          if (wr_acc && paddr == SRT_OFF_INSTR) begin
            state_r <= SRT_EXEC;
          end
        end
        SRT_EXEC: state_r <= SRT_IDLE;
        default:  state_r <= SRT_IDLE;
      endcase
    end
  end

  // Instruction and operand latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_r   <= SRT_ZERO_WORD;
      operand_r <= SRT_ZERO_WORD;
    end else if (wr_acc) begin
      if (paddr == SRT_OFF_INSTR && state_r == SRT_IDLE) begin
        instr_r <= pwdata;
      end else if (paddr == SRT_OFF_OPERAND) begin
        operand_r <= pwdata;
      end
    end
  end

  // Current status word update
  always_comb begin
    cur_nxt = cur_r;
    if (do_exec && (is_wr_full || is_wr_flag) && !psel_bit) begin
      if (privileged) begin
        cur_nxt = wr_val;
      end else begin
        // Control bits stay put outside privileged modes
        cur_nxt = {wr_val[SRT_COND_HI:SRT_FLAG_LO],
                   cur_r[SRT_CTRL_HI:0]};
      end
    end else if (wr_acc && paddr == SRT_OFF_CUR) begin
      cur_nxt = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_r <= SRT_CUR_RST;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Banked saved words; user and system mode have none to write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SRT_NBANK; i++) begin
        saved_r[i] <= SRT_ZERO_WORD;
      end
    end else if (bank_ok) begin
      if (do_exec && (is_wr_full || is_wr_flag) && psel_bit) begin
        saved_r[bank_sel[2:0]] <= wr_val;
      end else if (wr_acc && paddr == SRT_OFF_SAVED) begin
        saved_r[bank_sel[2:0]] <= pwdata;
      end
    end
  end

  // Last read-form value, kept for software to read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= SRT_ZERO_WORD;
    end else if (do_exec && is_read) begin
      result_r <= psr_word;
    end
  end

  // Write-back strobe: one cycle per executed read form
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpr_wr_en   <= 1'b0;
      gpr_wr_idx  <= 4'h0;
      gpr_wr_data <= SRT_ZERO_WORD;
    end else begin
      gpr_wr_en <= 1'b0;
      if (do_exec && is_read) begin
        gpr_wr_en   <= 1'b1;
        gpr_wr_idx  <= instr_r[SRT_RD_HI:SRT_RD_LO];
        gpr_wr_data <= psr_word;
      end
    end
  end

  // Outcome flags of the last instruction
  always_comb begin
    status_nxt = status_r;
    if (state_r == SRT_EXEC) begin
      status_nxt = 4'h0;
      status_nxt[SRT_ST_DONE]  = cond_pass;
      status_nxt[SRT_ST_SKIP]  = !cond_pass;
      status_nxt[SRT_ST_UNDEF] = !(is_read || is_wr_full || is_wr_flag);
      // A saved-word write without a bank does nothing; a read form gets zero
      status_nxt[SRT_ST_NOBANK] = psel_bit && !bank_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 4'h0;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign cur_status = cur_r;

  // Read mux, looked up in the setup cycle so the answer needs no wait
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = SRT_ZERO_WORD;
    rd_hit  = 1'b1;
    if (paddr == SRT_OFF_INSTR) begin
      rd_word = instr_r;
    end else if (paddr == SRT_OFF_OPERAND) begin
      rd_word = operand_r;
    end else if (paddr == SRT_OFF_CUR) begin
      rd_word = cur_nxt;
    end else if (paddr == SRT_OFF_SAVED) begin
      rd_word = saved_cur;
    end else if (paddr == SRT_OFF_RESULT) begin
      rd_word = result_r;
    end else if (paddr == SRT_OFF_STATUS) begin
      rd_word = {28'h000_0000, status_nxt};
    end else begin
      rd_hit = 1'b0;
    end
  end

  logic setup_ph;
  assign setup_ph = psel && !penable;

  // APB answer: zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_ph;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_ph && !rd_hit;
    end
  end

  // Unmapped reads answer zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= SRT_ZERO_WORD;
    end else if (setup_ph) begin
      prdata <= rd_word;
    end
  end

endmodule

// file: src/srt_pkg.sv
// Shared constants for the status register transfer unit
package srt_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] SRT_OFF_INSTR   = 8'h00;
  localparam logic [7:0] SRT_OFF_OPERAND = 8'h04;
  localparam logic [7:0] SRT_OFF_CUR     = 8'h08;
  localparam logic [7:0] SRT_OFF_SAVED   = 8'h0c;
  localparam logic [7:0] SRT_OFF_RESULT  = 8'h10;
  localparam logic [7:0] SRT_OFF_STATUS  = 8'h14;

  // Reset values
  localparam logic [31:0] SRT_CUR_RST   = 32'h0000_00d3;
  localparam logic [31:0] SRT_ZERO_WORD = 32'h0000_0000;

  // Instruction fields
  localparam int SRT_COND_HI = 31;
  localparam int SRT_COND_LO = 28;
  localparam int SRT_PSEL    = 22;
  localparam int SRT_IMM_BIT = 25;
  localparam int SRT_RD_HI   = 15;
  localparam int SRT_RD_LO   = 12;
  localparam int SRT_ROT_HI  = 11;
  localparam int SRT_ROT_LO  = 8;
  localparam int SRT_IMM_HI  = 7;
  localparam int SRT_RM_HI   = 3;
  localparam int SRT_FLAG_LO = 28;
  localparam int SRT_CTRL_HI = 27;

  // Fixed-bit templates: mask selects the bits that must match
  localparam logic [31:0] SRT_RD_MASK   = 32'h0fbf_0fff;
  localparam logic [31:0] SRT_RD_MATCH  = 32'h010f_0000;
  localparam logic [31:0] SRT_WRF_MASK  = 32'h0fbf_fff0;
  localparam logic [31:0] SRT_WRF_MATCH = 32'h0129_f000;
  localparam logic [31:0] SRT_WRG_MASK  = 32'h0dbf_f000;
  localparam logic [31:0] SRT_WRG_MATCH = 32'h0128_f000;
  localparam logic [31:0] SRT_WRG_RMSK  = 32'h0000_0ff0;

  // Processor modes in the low five bits
  localparam logic [4:0] SRT_MODE_USR = 5'h10;
  localparam logic [4:0] SRT_MODE_FIQ = 5'h11;
  localparam logic [4:0] SRT_MODE_IRQ = 5'h12;
  localparam logic [4:0] SRT_MODE_SVC = 5'h13;
  localparam logic [4:0] SRT_MODE_ABT = 5'h17;
  localparam logic [4:0] SRT_MODE_UND = 5'h1b;
  localparam int         SRT_MODE_HI  = 4;

  // Saved status banks
  localparam int         SRT_NBANK    = 5;
  localparam logic [2:0] SRT_BANK_FIQ = 3'h0;
  localparam logic [2:0] SRT_BANK_IRQ = 3'h1;
  localparam logic [2:0] SRT_BANK_SVC = 3'h2;
  localparam logic [2:0] SRT_BANK_ABT = 3'h3;
  localparam logic [2:0] SRT_BANK_UND = 3'h4;

  // Status register bits
  localparam int SRT_ST_DONE   = 0;
  localparam int SRT_ST_SKIP   = 1;
  localparam int SRT_ST_UNDEF  = 2;
  localparam int SRT_ST_NOBANK = 3;

  // Condition codes
  localparam logic [3:0] SRT_C_EQ = 4'h0;
  localparam logic [3:0] SRT_C_NE = 4'h1;
  localparam logic [3:0] SRT_C_CS = 4'h2;
  localparam logic [3:0] SRT_C_CC = 4'h3;
  localparam logic [3:0] SRT_C_MI = 4'h4;
  localparam logic [3:0] SRT_C_PL = 4'h5;
  localparam logic [3:0] SRT_C_VS = 4'h6;
  localparam logic [3:0] SRT_C_VC = 4'h7;
  localparam logic [3:0] SRT_C_HI = 4'h8;
  localparam logic [3:0] SRT_C_LS = 4'h9;
  localparam logic [3:0] SRT_C_GE = 4'ha;
  localparam logic [3:0] SRT_C_LT = 4'hb;
  localparam logic [3:0] SRT_C_GT = 4'hc;
  localparam logic [3:0] SRT_C_LE = 4'hd;
  localparam logic [3:0] SRT_C_AL = 4'he;

  typedef enum logic [1:0] {
    SRT_IDLE = 2'b01,
    SRT_EXEC = 2'b10
  } srt_state_t;

endpackage

// file: src/srt_cond.sv
// Condition field evaluator against the current flags
`timescale 1ns/1ps
module srt_cond
  import srt_pkg::*;
(
  // Condition and flags
  input  wire logic [3:0] cond,
  input  wire logic [3:0] nzcv,
  // Verdict
  output logic            pass
);

  logic n, z, c, v;
  assign n = nzcv[3];
  assign z = nzcv[2];
  assign c = nzcv[1];
  assign v = nzcv[0];

  always_comb begin
    case (cond)
      SRT_C_EQ: pass = z;
      SRT_C_NE: pass = !z;
      SRT_C_CS: pass = c;
      SRT_C_CC: pass = !c;
      SRT_C_MI: pass = n;
      SRT_C_PL: pass = !n;
      SRT_C_VS: pass = v;
      SRT_C_VC: pass = !v;
      SRT_C_HI: pass = c && !z;
      SRT_C_LS: pass = !c || z;
      SRT_C_GE: pass = (n == v);
      SRT_C_LT: pass = (n != v);
      SRT_C_GT: pass = !z && (n == v);
      SRT_C_LE: pass = z || (n != v);
      SRT_C_AL: pass = 1'b1;
      // Never code: treated as false
      default:  pass = 1'b0;
    endcase
  end

endmodule

// file: verification/srt_xfer_chk.sv
// Port checker for the status register transfer unit
`timescale 1ns/1ps
module srt_xfer_chk
  import srt_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Results
  input wire logic        gpr_wr_en,
  input wire logic [31:0] cur_status
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc    = psel && penable;
  wire wr_cur = acc && pwrite && paddr == SRT_OFF_CUR;
  wire wr_ins = acc && pwrite && paddr == SRT_OFF_INSTR;

  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_access_a: assert property (pready |-> acc)
    else $error("ready outside access");
  unmapped_err_a: assert property (acc && paddr > SRT_OFF_STATUS |-> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (pready && paddr == SRT_OFF_CUR |-> !pslverr)
    else $error("error on mapped address");
  gpr_cause_a: assert property (gpr_wr_en |-> $past(wr_ins, 2))
    else $error("result write without instruction");
  gpr_pulse_a: assert property (gpr_wr_en |=> !gpr_wr_en)
    else $error("result write longer than a cycle");
  user_ctrl_a: assert property (cur_status[4:0] == SRT_MODE_USR
    && !wr_cur |=> cur_status[27:0] == $past(cur_status[27:0]))
    else $error("control bits changed in user mode");
  cur_cause_a: assert property (!$stable(cur_status)
    |-> $past(wr_cur) || $past(wr_ins, 2))
    else $error("status word changed without cause");
endmodule

bind srt_xfer srt_xfer_chk chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .gpr_wr_en(gpr_wr_en),
  .cur_status(cur_status));

// file: verification/status_register_transfer_test.sv
// Random and corner-case bench for the status register transfer unit
`timescale 1ns/1ps
module status_register_transfer_test;
  import srt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        gpr_wr_en;
  logic [7:0]  paddr;
  logic [3:0]  gpr_wr_idx, f, c;
  logic [31:0] pwdata, prdata, gpr_wr_data, cur_status, rdat, op, old;
  logic [31:0] sv [5];
  logic [4:0]  md [5] = '{SRT_MODE_FIQ, SRT_MODE_IRQ, SRT_MODE_SVC,
                          SRT_MODE_ABT, SRT_MODE_UND};
  int          n_mismatch, n_tests, seed, k;

  srt_xfer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpr_wr_en(gpr_wr_en), .gpr_wr_idx(gpr_wr_idx),
    .gpr_wr_data(gpr_wr_data), .cur_status(cur_status));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task close_out;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Holds the request until ready is seen, with no bound of its own
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task gw(input logic [3:0] i, input logic [31:0] d);
    int t;
    t = 0;
    while (gpr_wr_en !== 1'b1 && t < 8) begin
      @(posedge pclk);
      t++;
    end
    chk(32'(gpr_wr_en), 32'h1);
    chk(32'(gpr_wr_idx), 32'(i));
    chk(gpr_wr_data, d);
  endtask

  function logic ok(input logic [3:0] c, input logic [3:0] f);
    case (c)
      4'h0: ok = f[2];
      4'h1: ok = !f[2];
      4'h2: ok = f[1];
      4'h3: ok = !f[1];
      4'h4: ok = f[3];
      4'h5: ok = !f[3];
      4'h6: ok = f[0];
      4'h7: ok = !f[0];
      4'h8: ok = f[1] && !f[2];
      4'h9: ok = !f[1] || f[2];
      4'ha: ok = f[3] == f[0];
      4'hb: ok = f[3] != f[0];
      4'hc: ok = !f[2] && f[3] == f[0];
      4'hd: ok = f[2] || f[3] != f[0];
      4'he: ok = 1'b1;
      default: ok = 1'b0;
    endcase
  endfunction

  initial begin
    #2_000_000;
    n_mismatch++;
    close_out;
  end

  initial begin
    seed = 42557;
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk(cur_status, SRT_CUR_RST);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(err), 32'h1);
    // All codes first, then random ones; odd passes use the immediate
    for (k = 0; k < 40; k++) begin
      f = 4'($random(seed));
      c = k < 16 ? 4'(k) : 4'($random(seed));
      op = $random(seed);
      old = {f, 28'h00000d3};
      apb(1'b1, SRT_OFF_CUR, old);
      apb(1'b1, SRT_OFF_OPERAND, op);
      apb(1'b1, SRT_OFF_INSTR, k[0] ? {c, 20'h328f4, op[7:0]}
                                    : {c, 28'h128f000});
      apb(1'b0, SRT_OFF_CUR, 32'h0);
      chk(rdat, ok(c, f) ? {k[0] ? op[7:4] : op[31:28], old[27:0]}
                         : old);
    end
    // T bit kept clear, mode legal
    op = $random(seed);
    op = {op[31:8], op[7:6], 1'b0, SRT_MODE_ABT};
    apb(1'b1, SRT_OFF_OPERAND, op);
    apb(1'b1, SRT_OFF_INSTR, 32'he129f000);
    apb(1'b0, SRT_OFF_CUR, 32'h0);
    chk(rdat, op);
    apb(1'b1, SRT_OFF_CUR, 32'h10);
    op = $random(seed);
    apb(1'b1, SRT_OFF_OPERAND, op);
    // User mode: only the flag bits of the current word are written, control bits stay
    apb(1'b1, SRT_OFF_INSTR, 32'he129f000);
    apb(1'b0, SRT_OFF_CUR, 32'h0);
    chk(rdat, {op[31:28], 28'h10});
    chk(cur_status, {op[31:28], 28'h10});
    for (k = 0; k < 10; k++) begin
      apb(1'b1, SRT_OFF_CUR, {24'h0, 3'b110, md[k % 5]});
      if (k < 5) begin
        sv[k] = $random(seed);
        apb(1'b1, SRT_OFF_OPERAND, sv[k]);
        apb(1'b1, SRT_OFF_INSTR, 32'he169f000);
      end else begin
        apb(1'b1, SRT_OFF_INSTR, {16'he14f, 4'(k), 12'h0});
        gw(4'(k), sv[k - 5]);
        apb(1'b1, SRT_OFF_INSTR, {16'he10f, 4'(k + 2), 12'h0});
        gw(4'(k + 2), {24'h0, 3'b110, md[k - 5]});
      end
    end
    // The last read form left the und mode word behind
    apb(1'b0, SRT_OFF_RESULT, 32'h0);
    chk(rdat, {24'h0, 3'b110, SRT_MODE_UND});
    // Set-flags bit makes it an ordinary compare: no transfer
    old = cur_status;
    apb(1'b1, SRT_OFF_INSTR, 32'he139f000);
    apb(1'b0, SRT_OFF_STATUS, 32'h0);
    chk(32'(rdat[SRT_ST_UNDEF]), 32'h1);
    chk(cur_status, old);
    close_out;
  end
endmodule
